/* File: hdl/ppot_pad_ctrl.sv */
`timescale 1ns/1ps
module ppot_pad_ctrl (
    input  wire logic  core_clk,
    input  wire logic  rst_b,
    ppot_pad_if.pad    pads
);
    import ppot_pkg::*;

    ppot_pins_t next_pd;
    ppot_pins_t next_pu;
    ppot_pins_t next_rail;

    // One resistor decision per pin; input direction takes precedence
    for (genvar i = 0; i < PPOT_NPINS; i++) begin : g_pin
        logic od_out;
        assign od_out = pads.output_dir[i] & pads.open_drain[i]
                        & ~pads.input_dir[i];
        assign next_pd[i] = pads.input_dir[i] & pads.pull_ctrl[i];
        assign next_pu[i] = od_out & pads.pull_ctrl[i];
        // Rail only meaningful while the pull-up is on
        assign next_rail[i] = next_pu[i] & pads.drive_type[i];
    end

    // Registered so the analog switches never see decode glitches
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pads.pd_en   <= '0;
            pads.pu_en   <= '0;
            pads.pu_rail <= '0;
        end else begin
            pads.pd_en   <= next_pd;
            pads.pu_en   <= next_pu;
            pads.pu_rail <= next_rail;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    pull_down_on_a: assert property (
        (pads.input_dir & pads.pull_ctrl) != '0 |=>
        (pads.pd_en & $past(pads.input_dir & pads.pull_ctrl))
        == $past(pads.input_dir & pads.pull_ctrl))
        else $error("pull-down not connected for input pin");
    pull_up_on_a: assert property (
        ##1 (pads.pu_en == $past(pads.output_dir & pads.open_drain
            & ~pads.input_dir & pads.pull_ctrl)))
        else $error("pull-up state does not follow control bit");
    pull_up_off_a: assert property (
        ##1 ((pads.pu_en & ~$past(pads.pull_ctrl)) == '0))
        else $error("pull-up connected while control bit is zero");
    rail_select_a: assert property (
        ##1 ((pads.pu_rail & ~pads.pu_en) == '0) and
        ##1 ((pads.pu_rail ^ $past(pads.drive_type)) & pads.pu_en) == '0)
        else $error("pull-up rail does not follow drive type");
endmodule : ppot_pad_ctrl

/* File: hdl/ppot_regs.sv */
`timescale 1ns/1ps
// What this block does
// - Input pin: pull bit switches pull-down
// - Open-drain output: bit one connects pull-up
// - Open-drain output: bit zero leaves pull-up off
// - Pull-up rail follows pin drive type
// - Signed 4-bit oscillator offset in bits 7:4
module ppot_regs (
    input  wire logic                core_clk,
    input  wire logic                rst_b,
    input  wire ppot_pkg::ppot_addr_t reg_addr,
    input  wire ppot_pkg::ppot_byte_t reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output      ppot_pkg::ppot_byte_t reg_rdata,
    input  wire ppot_pkg::ppot_pins_t pin_input_dir,
    input  wire ppot_pkg::ppot_pins_t pin_output_dir,
    input  wire ppot_pkg::ppot_pins_t pin_open_drain,
    input  wire ppot_pkg::ppot_pins_t pin_drive_type,
    output      ppot_pkg::ppot_pins_t pin_pull_down_en,
    output      ppot_pkg::ppot_pins_t pin_pull_up_en,
    output      ppot_pkg::ppot_pins_t pin_pull_up_rail,
    output      ppot_pkg::ppot_trim_t osc_freq_offset
);
    import ppot_pkg::*;

    ppot_byte_t pull_lo;
    ppot_byte_t pull_hi;
    ppot_trim_t osc_trim;
    ppot_byte_t spare;
    ppot_byte_t next_rdata;
    ppot_pins_t pin_pull_ctrl;
    logic       wr_pull_lo;
    logic       wr_pull_hi;
    logic       wr_osc;
    logic       wr_spare;

    ppot_pad_if pads ();

    // Write decode; one strobe per register
    assign wr_pull_lo = reg_wr & ppot_hit(reg_addr, PPOT_PULL_LO_OFF);
    assign wr_pull_hi = reg_wr & ppot_hit(reg_addr, PPOT_PULL_HI_OFF);
    assign wr_osc     = reg_wr & ppot_hit(reg_addr, PPOT_OSC_OFF);
    assign wr_spare   = reg_wr & ppot_hit(reg_addr, PPOT_SPARE_OFF);

    // Pull control for pins 0 to 7
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pull_lo <= PPOT_PULL_LO_RST;
        end else if (wr_pull_lo) begin
            pull_lo <= reg_wdata;
        end
    end

    // Pull control for pins 8 to 15
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pull_hi <= PPOT_PULL_HI_RST;
        end else if (wr_pull_hi) begin
            pull_hi <= reg_wdata;
        end
    end

    // Oscillator trim; low nibble is reserved and not stored
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            osc_trim <= PPOT_OSC_RST;
        end else if (wr_osc) begin
            osc_trim <= reg_wdata[PPOT_OSC_MSB:PPOT_OSC_LSB];
        end
    end

    // Spare byte is plain storage, kept so software sees what it wrote
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            spare <= PPOT_SPARE_RST;
        end else if (wr_spare) begin
            spare <= reg_wdata;
        end
    end

    // Trim code goes to the oscillator as two's complement, 1.33 % a step
    assign osc_freq_offset = osc_trim;

    // Bit n of the pin vector comes from the register holding pin n
    assign pin_pull_ctrl = {pull_hi, pull_lo};

    // Settings handed to the pad controller
    assign pads.pull_ctrl  = pin_pull_ctrl;
    assign pads.input_dir  = pin_input_dir;
    assign pads.output_dir = pin_output_dir;
    assign pads.open_drain = pin_open_drain;
    assign pads.drive_type = pin_drive_type;

    ppot_pad_ctrl u_pad_ctrl (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .pads     (pads.pad)
    );

    // Resistor controls come straight from the pad controller's flops
    assign pin_pull_down_en = pads.pd_en;
    assign pin_pull_up_en   = pads.pu_en;
    assign pin_pull_up_rail = pads.pu_rail;

    // Read mux; the status words show what the pads really do now,
    // which differs from the control bits when a pin is push-pull
    always_comb begin
        next_rdata = PPOT_UNMAPPED;
        if (ppot_hit(reg_addr, PPOT_PULL_LO_OFF)) begin
            next_rdata = pull_lo;
        end else if (ppot_hit(reg_addr, PPOT_PULL_HI_OFF)) begin
            next_rdata = pull_hi;
        end else if (ppot_hit(reg_addr, PPOT_OSC_OFF)) begin
            next_rdata = {osc_trim, 4'h0};
        end else if (ppot_hit(reg_addr, PPOT_SPARE_OFF)) begin
            next_rdata = spare;
        end else if (ppot_hit(reg_addr, PPOT_PD_LO_OFF)) begin
            next_rdata = pads.pd_en[PPOT_HI_BASE-1:0];
        end else if (ppot_hit(reg_addr, PPOT_PD_HI_OFF)) begin
            next_rdata = pads.pd_en[PPOT_NPINS-1:PPOT_HI_BASE];
        end else if (ppot_hit(reg_addr, PPOT_PU_LO_OFF)) begin
            next_rdata = pads.pu_en[PPOT_HI_BASE-1:0];
        end else if (ppot_hit(reg_addr, PPOT_PU_HI_OFF)) begin
            next_rdata = pads.pu_en[PPOT_NPINS-1:PPOT_HI_BASE];
        end
    end

    // Read data stands for one cycle only, zero otherwise
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // Any address the read mux answers; all else must read as unmapped
    function automatic logic rd_mapped(input ppot_addr_t addr);
        return ppot_hit(addr, PPOT_PULL_LO_OFF)
            || ppot_hit(addr, PPOT_PULL_HI_OFF)
            || ppot_hit(addr, PPOT_OSC_OFF)
            || ppot_hit(addr, PPOT_SPARE_OFF)
            || ppot_hit(addr, PPOT_PD_LO_OFF)
            || ppot_hit(addr, PPOT_PD_HI_OFF)
            || ppot_hit(addr, PPOT_PU_LO_OFF)
            || ppot_hit(addr, PPOT_PU_HI_OFF);
    endfunction : rd_mapped

    // Single-cycle write strobes, and the trim read that follows a trim write
    sequence s_wr_lo;
        reg_wr && ppot_hit(reg_addr, PPOT_PULL_LO_OFF);
    endsequence
    sequence s_wr_hi;
        reg_wr && ppot_hit(reg_addr, PPOT_PULL_HI_OFF);
    endsequence
    sequence s_wr_osc;
        reg_wr && ppot_hit(reg_addr, PPOT_OSC_OFF);
    endsequence
    sequence s_rd_osc;
        reg_rd && ppot_hit(reg_addr, PPOT_OSC_OFF);
    endsequence
    // Single-cycle reads of each place, for the read path checks
    sequence s_rd_lo;
        reg_rd && ppot_hit(reg_addr, PPOT_PULL_LO_OFF);
    endsequence
    sequence s_rd_hi;
        reg_rd && ppot_hit(reg_addr, PPOT_PULL_HI_OFF);
    endsequence
    sequence s_rd_spare;
        reg_rd && ppot_hit(reg_addr, PPOT_SPARE_OFF);
    endsequence
    sequence s_rd_pd_lo;
        reg_rd && ppot_hit(reg_addr, PPOT_PD_LO_OFF);
    endsequence
    sequence s_rd_pd_hi;
        reg_rd && ppot_hit(reg_addr, PPOT_PD_HI_OFF);
    endsequence
    sequence s_rd_pu_lo;
        reg_rd && ppot_hit(reg_addr, PPOT_PU_LO_OFF);
    endsequence
    sequence s_rd_pu_hi;
        reg_rd && ppot_hit(reg_addr, PPOT_PU_HI_OFF);
    endsequence
    sequence s_rd_none;
        reg_rd && !rd_mapped(reg_addr);
    endsequence

    low_group_map_a: assert property (
        s_wr_lo |=> pin_pull_ctrl[PPOT_HI_BASE-1:0] == $past(reg_wdata))
        else $error("low pull register does not map to pins 0-7");

    high_group_map_a: assert property (
        s_wr_hi |=>
        pin_pull_ctrl[PPOT_NPINS-1:PPOT_HI_BASE] == $past(reg_wdata))
        else $error("high pull register does not map to pins 8-15");

    group_isolate_a: assert property (
        s_wr_lo |=> pull_hi == $past(pull_hi))
        else $error("low write disturbed high pull register");

    osc_field_a: assert property (
        s_wr_osc |=> osc_freq_offset ==
        $past(reg_wdata[PPOT_OSC_MSB:PPOT_OSC_LSB]))
        else $error("oscillator offset not taken from bits 7:4");

    osc_readback_a: assert property (
        s_wr_osc ##1 s_rd_osc |=>
        reg_rdata == {$past(reg_wdata, 2) & 8'hF0})
        else $error("oscillator trim read back wrong");

    osc_hold_a: assert property (
        !wr_osc |=> $stable(osc_freq_offset))
        else $error("oscillator offset changed without a write");

    pad_pull_down_a: assert property (
        s_wr_lo ##1 (pin_input_dir[0] && pull_lo[0]) |=>
        pin_pull_down_en[0])
        else $error("pin 0 pull-down not connected after write");

    pad_pull_up_a: assert property (
        ##2 ((pin_pull_up_en & ~$past(pin_pull_ctrl)) == '0))
        else $error("pull-up on while its control bit was zero");

    rail_follow_a: assert property (
        ##1 ((pin_pull_up_rail ^ $past(pin_drive_type))
             & pin_pull_up_en) == '0)
        else $error("pull-up rail differs from drive type");

    read_only_once_a: assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data present without a read");

    // Read path: every stored register comes back as it stands
    low_readback_a: assert property (
        s_rd_lo |=> reg_rdata == $past(pull_lo))
        else $error("low pull register read back wrong");

    high_readback_a: assert property (
        s_rd_hi |=> reg_rdata == $past(pull_hi))
        else $error("high pull register read back wrong");

    spare_readback_a: assert property (
        s_rd_spare |=> reg_rdata == $past(spare))
        else $error("spare register read back wrong");

    osc_low_zero_a: assert property (
        s_rd_osc |=> reg_rdata[PPOT_OSC_LSB-1:0] == '0)
        else $error("reserved trim bits did not read as zero");

    unmapped_zero_a: assert property (
        s_rd_none |=> reg_rdata == PPOT_UNMAPPED)
        else $error("unmapped address returned data");

    high_isolate_a: assert property (
        s_wr_hi |=> pull_lo == $past(pull_lo))
        else $error("high write disturbed low pull register");

    // Status words mirror the pad controls of the cycle of the strobe
    pd_status_lo_a: assert property (
        s_rd_pd_lo |=>
        reg_rdata == $past(pin_pull_down_en[PPOT_HI_BASE-1:0]))
        else $error("pull-down status of pins 0-7 wrong");

    pd_status_hi_a: assert property (
        s_rd_pd_hi |=>
        reg_rdata == $past(pin_pull_down_en[PPOT_NPINS-1:PPOT_HI_BASE]))
        else $error("pull-down status of pins 8-15 wrong");

    pu_status_lo_a: assert property (
        s_rd_pu_lo |=>
        reg_rdata == $past(pin_pull_up_en[PPOT_HI_BASE-1:0]))
        else $error("pull-up status of pins 0-7 wrong");

    pu_status_hi_a: assert property (
        s_rd_pu_hi |=>
        reg_rdata == $past(pin_pull_up_en[PPOT_NPINS-1:PPOT_HI_BASE]))
        else $error("pull-up status of pins 8-15 wrong");

    // Resistor outputs stay off wherever the rules give no resistor
    pull_down_off_a: assert property (
        ##1 ((pin_pull_down_en
              & ~($past(pin_pull_ctrl) & $past(pin_input_dir))) == '0))
        else $error("pull-down on without input pin and set bit");

    push_pull_quiet_a: assert property (
        ##1 ((pin_pull_up_en & ~$past(pin_open_drain)) == '0))
        else $error("pull-up on for a push-pull pin");

    input_wins_a: assert property (
        ##1 ((pin_pull_up_en & $past(pin_input_dir)) == '0))
        else $error("pull-up on for a pin set as input");

    rail_off_a: assert property (
        ##1 ((pin_pull_up_rail & ~pin_pull_up_en) == '0))
        else $error("pull-up rail selected with pull-up off");

    // Stored settings move only when their own strobe hits
    pull_hold_a: assert property (
        !wr_pull_lo && !wr_pull_hi |=> $stable(pin_pull_ctrl))
        else $error("pull control changed without a write");

    spare_hold_a: assert property (
        !wr_spare |=> $stable(spare))
        else $error("spare register changed without a write");

endmodule : ppot_regs

/* File: include/ppot_pad_if.sv */
`timescale 1ns/1ps
interface ppot_pad_if;
    import ppot_pkg::*;

    ppot_pins_t pull_ctrl;
    ppot_pins_t input_dir;
    ppot_pins_t output_dir;
    ppot_pins_t open_drain;
    ppot_pins_t drive_type;
    ppot_pins_t pd_en;
    ppot_pins_t pu_en;
    ppot_pins_t pu_rail;

    // Register side drives the settings, pad side the resistor controls
    modport cfg (output pull_ctrl, output input_dir, output output_dir,
                 output open_drain, output drive_type,
                 input pd_en, input pu_en, input pu_rail);
    modport pad (input pull_ctrl, input input_dir, input output_dir,
                 input open_drain, input drive_type,
                 output pd_en, output pu_en, output pu_rail);
endinterface : ppot_pad_if

/* File: include/ppot_pkg.sv */
package ppot_pkg;

    // Widths of the block
    localparam int unsigned PPOT_NPINS   = 16;
    localparam int unsigned PPOT_AW      = 9;
    localparam int unsigned PPOT_DW      = 8;

    typedef logic [PPOT_AW-1:0]    ppot_addr_t;
    typedef logic [PPOT_DW-1:0]    ppot_byte_t;
    typedef logic [PPOT_NPINS-1:0] ppot_pins_t;
    typedef logic signed [3:0]     ppot_trim_t;

    // Register offsets
    localparam ppot_addr_t PPOT_PULL_LO_OFF = 9'h110;
    localparam ppot_addr_t PPOT_PULL_HI_OFF = 9'h111;
    localparam ppot_addr_t PPOT_OSC_OFF     = 9'h112;
    localparam ppot_addr_t PPOT_SPARE_OFF   = 9'h113;
    localparam ppot_addr_t PPOT_PD_LO_OFF   = 9'h1F0;
    localparam ppot_addr_t PPOT_PD_HI_OFF   = 9'h1F1;
    localparam ppot_addr_t PPOT_PU_LO_OFF   = 9'h1F2;
    localparam ppot_addr_t PPOT_PU_HI_OFF   = 9'h1F3;

    // Field positions
    localparam int unsigned PPOT_HI_BASE    = 8;
    localparam int unsigned PPOT_OSC_LSB    = 4;
    localparam int unsigned PPOT_OSC_MSB    = 7;

    // Reset values, and the value read back at unmapped addresses
    localparam ppot_byte_t PPOT_PULL_LO_RST = 8'h00;
    localparam ppot_byte_t PPOT_PULL_HI_RST = 8'h00;
    localparam ppot_trim_t PPOT_OSC_RST     = 4'h0;
    localparam ppot_byte_t PPOT_SPARE_RST   = 8'h00;
    localparam ppot_byte_t PPOT_UNMAPPED    = 8'h00;

    // Address match, used by the write and the read decode
    function automatic logic ppot_hit(input ppot_addr_t addr,
                                      input ppot_addr_t off);
        return addr == off;
    endfunction : ppot_hit

endpackage : ppot_pkg

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
    n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module tb;
    import ppot_pkg::*;

    localparam int LIMIT = 4000;

    logic       core_clk;
    logic       rst_b;
    ppot_addr_t reg_addr;
    ppot_byte_t reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    ppot_byte_t reg_rdata;
    ppot_pins_t in_dir;
    ppot_pins_t out_dir;
    ppot_pins_t od;
    ppot_pins_t dtype;
    ppot_pins_t pd_en;
    ppot_pins_t pu_en;
    ppot_pins_t pu_rail;
    ppot_trim_t trim;
    int         n_errors;
    int         checks;
    int         cycles;

    ppot_regs dut_u (
        .core_clk         (core_clk),
        .rst_b            (rst_b),
        .reg_addr         (reg_addr),
        .reg_wdata        (reg_wdata),
        .reg_wr           (reg_wr),
        .reg_rd           (reg_rd),
        .reg_rdata        (reg_rdata),
        .pin_input_dir    (in_dir),
        .pin_output_dir   (out_dir),
        .pin_open_drain   (od),
        .pin_drive_type   (dtype),
        .pin_pull_down_en (pd_en),
        .pin_pull_up_en   (pu_en),
        .pin_pull_up_rail (pu_rail),
        .osc_freq_offset  (trim)
    );

    // 20 MHz clock
    always #25 core_clk = ~core_clk;

    // Verdict and end of run, shared by the main flow and the timeout
    task automatic stop_test;
        if (n_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    // Hang guard: far above the 130 or so cycles the tests need
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_errors++;
            stop_test();
        end
    end

    // One-cycle write; an idle edge follows so strobes never double up
    task automatic wr(input ppot_addr_t a, input ppot_byte_t d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask : wr

    // Read data only stands in the cycle after the strobe
    task automatic rd(input ppot_addr_t a, input ppot_byte_t e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        `CHK(reg_rdata, e)
        @(posedge core_clk);
    endtask : rd

    // Pad controls lag inputs by one cycle, so let two edges pass
    task automatic pins(input ppot_pins_t pd, input ppot_pins_t pu,
                        input ppot_pins_t rail);
        @(posedge core_clk);
        @(negedge core_clk);
        `CHK(pd_en, pd)
        `CHK(pu_en, pu)
        `CHK(pu_rail, rail)
        @(posedge core_clk);
    endtask : pins

    // Main sequence
    initial begin
        core_clk = 1'b0;
        rst_b = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        {in_dir, out_dir, od, dtype} = '0;
        n_errors = 0;
        checks = 0;
        cycles = 0;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        // Reset state of the four stored registers
        for (int i = 0; i < 4; i++) begin
            rd(PPOT_PULL_LO_OFF + 9'(i), 8'h00);
        end
        // Inputs: pull bits switch pull-downs, split across two registers
        in_dir <= 16'hFFFF;
        wr(PPOT_PULL_LO_OFF, 8'h5A);
        wr(PPOT_PULL_HI_OFF, 8'hC3);
        pins(16'hC35A, 16'h0000, 16'h0000);
        rd(PPOT_PULL_LO_OFF, 8'h5A);
        rd(PPOT_PULL_HI_OFF, 8'hC3);
        rd(PPOT_PD_HI_OFF, 8'hC3);
        // Open-drain outputs: pull-ups on their chosen rail
        in_dir <= 16'h0000;
        out_dir <= 16'hFFFF;
        od <= 16'hFFFF;
        dtype <= 16'h0F0F;
        pins(16'h0000, 16'hC35A, 16'h030A);
        rd(PPOT_PU_LO_OFF, 8'h5A);
        rd(PPOT_PU_HI_OFF, 8'hC3);
        wr(PPOT_PULL_LO_OFF, 8'h00);
        pins(16'h0000, 16'hC300, 16'h0300);
        // Push-pull outputs get no resistor at all
        od <= 16'h0000;
        pins(16'h0000, 16'h0000, 16'h0000);
        // Both directions set: input wins
        in_dir <= 16'hFFFF;
        od <= 16'hFFFF;
        pins(16'hC300, 16'h0000, 16'h0000);
        // Pin 0 set as input with its pull bit set
        wr(PPOT_PULL_LO_OFF, 8'h01);
        pins(16'hC301, 16'h0000, 16'h0000);
        // Every trim code, low nibble not stored
        for (int i = 0; i < 16; i++) begin
            wr(PPOT_OSC_OFF, {4'(i), 4'hF});
            `CHK(trim, 4'(i))
            rd(PPOT_OSC_OFF, {4'(i), 4'h0});
        end
        // Write then read of the trim with no gap between the strobes
        reg_addr  <= PPOT_OSC_OFF;
        reg_wdata <= 8'h9C;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        `CHK(reg_rdata, 8'h90)
        @(posedge core_clk);
        // Spare storage, unmapped and read-only places
        wr(PPOT_SPARE_OFF, 8'hA5);
        rd(PPOT_SPARE_OFF, 8'hA5);
        wr(9'h114, 8'hFF);
        rd(9'h114, 8'h00);
        wr(PPOT_PD_LO_OFF, 8'hFF);
        rd(PPOT_PD_LO_OFF, 8'h01);
        // Second reset in mid-run clears everything
        rst_b <= 1'b0;
        @(negedge core_clk);
        `CHK(pd_en, 16'h0000)
        `CHK(trim, 4'h0)
        @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        rd(PPOT_PULL_HI_OFF, 8'h00);
        stop_test();
    end
endmodule : tb
